// [shared/sysctl_consts.svh]
// Offsets, field positions and reset values of the system control slice
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH

// Register byte offsets
`define OFS_REGULATOR_VOLTAGE 12'h034
`define OFS_SOFT_RESET_A      12'h040
`define OFS_SOFT_RESET_B      12'h044
`define OFS_SOFT_RESET_C      12'h048
`define OFS_RAW_EVENT_STATUS  12'h050

// Reset values
`define RST_REGULATOR_VOLTAGE 32'h0000_0000
`define RST_SOFT_RESET        32'h0000_0000
`define RST_RAW_EVENT         7'h00

// Implemented bits of each register
`define IMPL_REGULATOR_VOLTAGE 32'h0000_003F
`define IMPL_SOFT_RESET_A      32'h0000_0008
`define IMPL_SOFT_RESET_B      32'h0303_0011
`define IMPL_SOFT_RESET_C      32'h0000_0007
`define IMPL_RAW_EVENT         32'h0000_007F

// Field positions
`define POS_VOLTAGE_MSB   5
`define POS_WATCHDOG      3
`define POS_COMPARATOR1   25
`define POS_COMPARATOR0   24
`define POS_TIMER1        17
`define POS_TIMER0        16
`define POS_SYNC_SERIAL   4
`define POS_SERIAL_PORT0  0
`define POS_GPIO_C        2
`define POS_GPIO_B        1
`define POS_GPIO_A        0
`define POS_PLL_LOCK      6
`define POS_CURRENT_LIMIT 5
`define POS_INT_OSC_FAULT 4
`define POS_MAIN_OSC_FAULT 3
`define POS_UNREGULATED   2
`define POS_BROWNOUT      1
`define POS_PLL_FAULT     0

// Widths
`define EVENT_COUNT 7
`define SYNC_DEPTH  3

`endif

// [shared/sysctl_pkg.sv]
// Types shared by the system control slice
package sysctl_pkg;
    typedef logic [31:0] word_t;
    typedef logic [3:0]  lanes_t;
    typedef logic [6:0]  event_vec_t;
    typedef enum {
        SLOT_VOLTAGE,
        SLOT_RESET_A,
        SLOT_RESET_B,
        SLOT_RESET_C,
        SLOT_RAW_STATUS,
        SLOT_NONE
    } reg_slot_t;
endpackage

// [shared/event_bus_if.sv]
// Raw event flags and their clear strobes between tracker and register bank
`timescale 1ns/10ps
interface event_bus_if;
    logic [6:0] raw;
    logic [6:0] clear;
    modport tracker (output raw, input clear);
    modport bank    (input raw, output clear);
endinterface

// [hdl/raw_event_tracker.sv]
// Synchronised sticky raw event flags set by hardware
`timescale 1ns/10ps
`include "sysctl_consts.svh"
module raw_event_tracker
    import sysctl_pkg::*;
(
    // Clock and control
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // Event sources from outside the clock domain
    input  wire logic [6:0] eventPins,
    // Flags and clears
    event_bus_if.tracker    evt
);
    logic [6:0] syncA;
    logic [6:0] syncB;
    logic [6:0] syncC;
    logic [6:0] level;
    logic [6:0] flags;
    logic [6:0] next_syncA;
    logic [6:0] next_syncB;
    logic [6:0] next_syncC;
    logic [6:0] next_level;
    logic [6:0] next_flags;

    genvar g;
    generate
        for (g = 0; g < `EVENT_COUNT; g++) begin : gEvent
            always_comb begin
                next_syncA[g] = eventPins[g];
                next_syncB[g] = syncA[g];
                next_syncC[g] = syncB[g];
                // Accept a change once two stages agree
                next_level[g] = (syncB[g] == syncC[g]) ? syncC[g] : level[g];
                // Hardware sets; a set in the clear cycle wins
                next_flags[g] = level[g] | (flags[g] & ~evt.clear[g]);
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            syncA <= `RST_RAW_EVENT;
            syncB <= `RST_RAW_EVENT;
            syncC <= `RST_RAW_EVENT;
            level <= `RST_RAW_EVENT;
            flags <= `RST_RAW_EVENT;
        end else if (clkEn) begin
            syncA <= next_syncA;
            syncB <= next_syncB;
            syncC <= next_syncC;
            level <= next_level;
            flags <= next_flags;
        end
    end

    assign evt.raw = flags;
endmodule // raw_event_tracker

// [hdl/system_control_regs.sv]
// System control register slice: regulator select, soft resets, raw events
// What this block does
// - Regulator select output follows voltage field bits 5:0, reset zero.
// - Soft reset writes are masked by matching capability bits.
// - Soft reset A has watchdog bit 3, others reserved.
// - Soft reset B: comparators 25/24, timers 17/16, sync serial 4, serial 0.
// - Soft reset C: GPIO banks C, B, A at bits 2, 1, 0.
// - Reserved bits read zero; software preserves them on writes.
// - Raw status is read-only, hardware set, reset zero.
// - Bit 6 sets when PLL ready timer asserts.
// - Bit 5 sets when regulator current limit asserts.
// - Bit 4 sets on internal oscillator fault.
// - Bit 3 sets on main oscillator fault.
// - Bit 2 sets while regulator output is unregulated.
// - Bit 1 sets on any brown-out condition.
// - Brown-out interrupt needs raw bit, mask bit, and select bit clear.
// - Bit 0 sets when the PLL stops oscillating.
// - Brown-out select set signals reset, clear signals interrupt.
// - Each mask bit promotes its raw bit to an interrupt, bit 1 only while brown-out select is clear.
// - Writing one to masked status clear also clears the raw bit.
`timescale 1ns/10ps
`include "sysctl_consts.svh"
module system_control_regs
    import sysctl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    // Wishbone slave
    input  wire logic              wbCyc,
    input  wire logic              wbStb,
    input  wire logic              wbWe,
    input  wire logic [ADDR_W-1:0] wbAdr,
    input  wire logic [3:0]        wbSel,
    input  wire logic [31:0]       wbDatIn,
    output logic      [31:0]       wbDatOut,
    output logic                   wbAck,
    // Capability masks
    input  wire logic [31:0]       capabilityRegisterOne,
    input  wire logic [31:0]       capabilityRegisterTwo,
    input  wire logic [31:0]       capabilityRegisterFour,
    // Event mask, clear and brown-out control from neighbouring registers
    input  wire logic [6:0]        eventMaskRegister,
    input  wire logic [6:0]        maskedStatusClear,
    input  wire logic              brownoutResetOrIrqSelect,
    // Event sources
    input  wire logic              pllReadyTimer,
    input  wire logic              currentLimitDetect,
    input  wire logic              internalOscFault,
    input  wire logic              mainOscFault,
    input  wire logic              supplyUnregulated,
    input  wire logic              brownoutDetect,
    input  wire logic              pllFaultDetect,
    // Regulator
    output logic      [5:0]        regulatorSelectInput,
    // Peripheral resets
    output logic                   watchdogReset,
    output logic                   comparatorOneReset,
    output logic                   comparatorZeroReset,
    output logic                   timerOneReset,
    output logic                   timerZeroReset,
    output logic                   syncSerialReset,
    output logic                   serialPortZeroReset,
    output logic                   gpioBankCReset,
    output logic                   gpioBankBReset,
    output logic                   gpioBankAReset,
    // Event outputs
    output logic      [6:0]        maskedEvents,
    output logic                   controllerIrq,
    output logic                   brownoutIrq,
    output logic                   brownoutResetReq
);
    event_bus_if evt ();

    word_t      voltageReg;
    word_t      resetA;
    word_t      resetB;
    word_t      resetC;
    logic       ack;
    word_t      readData;
    logic [6:0] masked;
    logic       irq;
    logic       borIrq;
    logic       borReset;
    logic [6:0] clearPulse;

    word_t      next_voltageReg;
    word_t      next_resetA;
    word_t      next_resetB;
    word_t      next_resetC;
    logic       next_ack;
    word_t      next_readData;
    logic [6:0] next_masked;
    logic       next_irq;
    logic       next_borIrq;
    logic       next_borReset;

    logic       request;
    logic       commitWrite;
    reg_slot_t  slot;
    word_t      laneMask;
    word_t      writeAllow;

    // Address decode
    function automatic reg_slot_t decodeSlot(input logic [ADDR_W-1:0] adr);
        reg_slot_t s;
        s = SLOT_NONE;
        unique case (adr)
            `OFS_REGULATOR_VOLTAGE: s = SLOT_VOLTAGE;
            `OFS_SOFT_RESET_A:      s = SLOT_RESET_A;
            `OFS_SOFT_RESET_B:      s = SLOT_RESET_B;
            `OFS_SOFT_RESET_C:      s = SLOT_RESET_C;
            `OFS_RAW_EVENT_STATUS:  s = SLOT_RAW_STATUS;
            default:                s = SLOT_NONE;
        endcase
        return s;
    endfunction

    // Byte enables to bit mask
    function automatic word_t lanesToMask(input lanes_t sel);
        word_t m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Masked merge of write data into a register
    function automatic word_t mergeWrite(input word_t old, input word_t wr,
                                         input word_t allow);
        return (old & ~allow) | (wr & allow);
    endfunction

    // Implemented bits of each register
    function automatic word_t implMask(input reg_slot_t s);
        word_t m;
        m = 32'h0000_0000;
        unique case (s)
            SLOT_VOLTAGE:    m = `IMPL_REGULATOR_VOLTAGE;
            SLOT_RESET_A:    m = `IMPL_SOFT_RESET_A;
            SLOT_RESET_B:    m = `IMPL_SOFT_RESET_B;
            SLOT_RESET_C:    m = `IMPL_SOFT_RESET_C;
            SLOT_RAW_STATUS: m = `IMPL_RAW_EVENT;
            SLOT_NONE:       m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    // Capability gate on each register's writes
    function automatic word_t capMask(input reg_slot_t s, input word_t one,
                                      input word_t two, input word_t four);
        word_t m;
        m = 32'h0000_0000;
        unique case (s)
            SLOT_VOLTAGE:    m = 32'hFFFF_FFFF;
            SLOT_RESET_A:    m = one;
            SLOT_RESET_B:    m = two;
            SLOT_RESET_C:    m = four;
            SLOT_RAW_STATUS: m = 32'h0000_0000;
            SLOT_NONE:       m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    raw_event_tracker uTracker (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        .eventPins ({pllReadyTimer,
                     currentLimitDetect,
                     internalOscFault,
                     mainOscFault,
                     supplyUnregulated,
                     brownoutDetect,
                     pllFaultDetect}),
        .evt       (evt.tracker)
    );

    // Clearing through the masked status register
    assign clearPulse = maskedStatusClear;
    assign evt.clear  = clearPulse;

    // Bus request handling
    always_comb begin
        request     = wbCyc & wbStb;
        slot        = decodeSlot(wbAdr);
        laneMask    = lanesToMask(wbSel);
        writeAllow  = laneMask & implMask(slot)
                      & capMask(slot, capabilityRegisterOne, capabilityRegisterTwo,
                                capabilityRegisterFour);
        commitWrite = request & wbWe & ack;
        next_ack    = request & ~ack;
    end

    // Read data captured with the answer; reserved bits read zero
    always_comb begin
        next_readData = readData;
        if (request & ~ack) begin
            unique case (slot)
                SLOT_VOLTAGE:    next_readData = voltageReg & implMask(slot);
                SLOT_RESET_A:    next_readData = resetA & implMask(slot);
                SLOT_RESET_B:    next_readData = resetB & implMask(slot);
                SLOT_RESET_C:    next_readData = resetC & implMask(slot);
                SLOT_RAW_STATUS: next_readData = {25'h000_0000, evt.raw};
                SLOT_NONE:       next_readData = 32'h0000_0000;
            endcase
        end
    end

    // Register writes at the edge that samples the answer
    always_comb begin
        next_voltageReg = voltageReg;
        next_resetA     = resetA;
        next_resetB     = resetB;
        next_resetC     = resetC;
        if (commitWrite) begin
            unique case (slot)
                SLOT_VOLTAGE: begin
                    next_voltageReg = mergeWrite(voltageReg, wbDatIn,
                        writeAllow);
                end
                SLOT_RESET_A: begin
                    next_resetA = mergeWrite(resetA, wbDatIn,
                        writeAllow);
                end
                SLOT_RESET_B: begin
                    next_resetB = mergeWrite(resetB, wbDatIn,
                        writeAllow);
                end
                SLOT_RESET_C: begin
                    next_resetC = mergeWrite(resetC, wbDatIn,
                        writeAllow);
                end
                SLOT_RAW_STATUS: begin
                    next_resetA = resetA;
                end
                SLOT_NONE: begin
                    next_resetA = resetA;
                end
            endcase
        end
    end

    // Interrupt promotion and brown-out routing
    always_comb begin
        next_masked   = evt.raw & eventMaskRegister;
        next_borIrq   = evt.raw[`POS_BROWNOUT] & eventMaskRegister[`POS_BROWNOUT]
                        & ~brownoutResetOrIrqSelect;
        next_borReset = evt.raw[`POS_BROWNOUT] & brownoutResetOrIrqSelect;
        next_irq      = |{next_masked[6:2], next_borIrq, next_masked[0]};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            voltageReg <= `RST_REGULATOR_VOLTAGE;
            resetA     <= `RST_SOFT_RESET;
            resetB     <= `RST_SOFT_RESET;
            resetC     <= `RST_SOFT_RESET;
            ack        <= 1'b0;
            readData   <= 32'h0000_0000;
            masked     <= 7'h00;
            irq        <= 1'b0;
            borIrq     <= 1'b0;
            borReset   <= 1'b0;
        end else if (clkEn) begin
            voltageReg <= next_voltageReg;
            resetA     <= next_resetA;
            resetB     <= next_resetB;
            resetC     <= next_resetC;
            ack        <= next_ack;
            readData   <= next_readData;
            masked     <= next_masked;
            irq        <= next_irq;
            borIrq     <= next_borIrq;
            borReset   <= next_borReset;
        end
    end

    // Outputs
    assign wbAck                = ack;
    assign wbDatOut             = readData;
    assign regulatorSelectInput = voltageReg[`POS_VOLTAGE_MSB:0];
    assign watchdogReset        = resetA[`POS_WATCHDOG];
    assign comparatorOneReset   = resetB[`POS_COMPARATOR1];
    assign comparatorZeroReset  = resetB[`POS_COMPARATOR0];
    assign timerOneReset        = resetB[`POS_TIMER1];
    assign timerZeroReset       = resetB[`POS_TIMER0];
    assign syncSerialReset      = resetB[`POS_SYNC_SERIAL];
    assign serialPortZeroReset  = resetB[`POS_SERIAL_PORT0];
    assign gpioBankCReset       = resetC[`POS_GPIO_C];
    assign gpioBankBReset       = resetC[`POS_GPIO_B];
    assign gpioBankAReset       = resetC[`POS_GPIO_A];
    assign maskedEvents         = masked;
    assign controllerIrq        = irq;
    assign brownoutIrq          = borIrq;
    assign brownoutResetReq     = borReset;
endmodule // system_control_regs

// [bench/system_control_regs_properties.sv]
// Concurrent checks on the system control register slice
`timescale 1ns/10ps
`include "sysctl_consts.svh"
module system_control_regs_properties
    import sysctl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Bus
    input wire logic              wbCyc,
    input wire logic              wbStb,
    input wire logic              wbWe,
    input wire logic [ADDR_W-1:0] wbAdr,
    input wire logic [3:0]        wbSel,
    input wire logic [31:0]       wbDatIn,
    input wire logic              wbAck,
    // Controls
    input wire logic [31:0]       capabilityRegisterOne,
    input wire logic [6:0]        eventMaskRegister,
    input wire logic              brownoutResetOrIrqSelect,
    input wire logic              supplyUnregulated,
    // Outputs
    input wire logic [5:0]        regulatorSelectInput,
    input wire logic              watchdogReset,
    input wire logic [6:0]        maskedEvents,
    input wire logic              controllerIrq,
    input wire logic              brownoutIrq,
    input wire logic              brownoutResetReq
);
    logic wrAck;
    logic wrVolt;
    assign wrAck = wbCyc && wbStb && wbWe && wbAck;
    assign wrVolt = wrAck && wbAdr == `OFS_REGULATOR_VOLTAGE && wbSel[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    reset_zero_a: assert property ($fell(sys_rst) |-> regulatorSelectInput == 6'h00)
        else $error("select not zero after reset");
    volt_write_a: assert property (wrVolt |=> regulatorSelectInput == $past(wbDatIn[5:0]))
        else $error("voltage field not applied");
    volt_hold_a: assert property (!wrVolt |=> $stable(regulatorSelectInput))
        else $error("select changed without write");
    wdog_mask_a: assert property (wrAck && wbAdr == `OFS_SOFT_RESET_A && wbSel[0] |=>
        watchdogReset == ($past(capabilityRegisterOne[3]) ? $past(wbDatIn[3])
        : $past(watchdogReset))) else $error("watchdog bit not masked");
    brown_irq_a: assert property (brownoutIrq |->
        $past(eventMaskRegister[1]) && !$past(brownoutResetOrIrqSelect))
        else $error("brownout irq without mask or with reset select");
    brown_rst_a: assert property (brownoutResetReq |->
        $past(brownoutResetOrIrqSelect) && !brownoutIrq)
        else $error("brownout reset without select");
    mask_gate_a: assert property ((maskedEvents & ~$past(eventMaskRegister)) == 7'h00)
        else $error("masked event without mask bit");
    irq_or_a: assert property (controllerIrq ==
        (|maskedEvents[6:2] || maskedEvents[0] || brownoutIrq)) else $error("irq mismatch");
    unreg_set_a: assert property ((supplyUnregulated && eventMaskRegister[2]) [*7] |=>
        maskedEvents[2]) else $error("unregulated flag not set");
    cover property (brownoutIrq);
    cover property (brownoutResetReq);
    cover property (wrVolt);
endmodule // system_control_regs_properties

bind system_control_regs system_control_regs_properties #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbAck(wbAck),
    .capabilityRegisterOne(capabilityRegisterOne), .eventMaskRegister(eventMaskRegister),
    .brownoutResetOrIrqSelect(brownoutResetOrIrqSelect), .supplyUnregulated(supplyUnregulated),
    .regulatorSelectInput(regulatorSelectInput), .watchdogReset(watchdogReset),
    .maskedEvents(maskedEvents), .controllerIrq(controllerIrq), .brownoutIrq(brownoutIrq),
    .brownoutResetReq(brownoutResetReq));

// [bench/system_control_regs_bench.sv]
// Self-checking bench for the system control register slice
`timescale 1ns/10ps
`include "sysctl_consts.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errTotal++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module system_control_regs_bench
    import sysctl_pkg::*;
;
    logic       core_clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, selBrown, ctlIrq, brIrq, brRst;
    logic [11:0] wbAdr;
    lanes_t     wbSel, s;
    word_t      wbDatIn, wbDatOut, capOne, capTwo, capFour, got, d, r, cap;
    event_vec_t evtMask, evtClr, evtPins, maskedEvents, m, bitv;
    logic [5:0] regSel;
    logic [9:0] rstOut;
    int         errTotal, compares, seed, k, c, b;
    word_t      sh [4];
    logic [11:0] adr [4] = '{`OFS_REGULATOR_VOLTAGE, `OFS_SOFT_RESET_A, `OFS_SOFT_RESET_B,
        `OFS_SOFT_RESET_C};
    word_t      impl [4] = '{`IMPL_REGULATOR_VOLTAGE, `IMPL_SOFT_RESET_A, `IMPL_SOFT_RESET_B,
        `IMPL_SOFT_RESET_C};

    system_control_regs dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
        .capabilityRegisterOne(capOne), .capabilityRegisterTwo(capTwo),
        .capabilityRegisterFour(capFour), .eventMaskRegister(evtMask),
        .maskedStatusClear(evtClr), .brownoutResetOrIrqSelect(selBrown),
        .pllReadyTimer(evtPins[6]), .currentLimitDetect(evtPins[5]),
        .internalOscFault(evtPins[4]), .mainOscFault(evtPins[3]),
        .supplyUnregulated(evtPins[2]), .brownoutDetect(evtPins[1]),
        .pllFaultDetect(evtPins[0]), .regulatorSelectInput(regSel),
        .watchdogReset(rstOut[9]), .comparatorOneReset(rstOut[8]),
        .comparatorZeroReset(rstOut[7]), .timerOneReset(rstOut[6]), .timerZeroReset(rstOut[5]),
        .syncSerialReset(rstOut[4]), .serialPortZeroReset(rstOut[3]),
        .gpioBankCReset(rstOut[2]), .gpioBankBReset(rstOut[1]), .gpioBankAReset(rstOut[0]),
        .maskedEvents(maskedEvents), .controllerIrq(ctlIrq), .brownoutIrq(brIrq),
        .brownoutResetReq(brRst));

    always #20 core_clk = ~core_clk;

    // Byte-lane, implemented-bit and capability merge of a write
    function automatic word_t merge(word_t old, word_t dv, lanes_t sv, word_t im, word_t cp);
        word_t mk;
        mk = im & cp & {{8{sv[3]}}, {8{sv[2]}}, {8{sv[1]}}, {8{sv[0]}}};
        return (old & ~mk) | (dv & mk);
    endfunction

    // Classic single cycle, held until ack
    task automatic xfer(input logic [11:0] a, input logic we, input lanes_t sl, input word_t dv);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= sl;
        wbDatIn <= dv;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        got = wbDatOut;
        if (n >= 20) errTotal++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge core_clk);
    endtask

    task conclude();
        if (errTotal == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        seed = 12;
        errTotal = 0;
        compares = 0;
        core_clk = 0;
        sys_rst = 1;
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn, selBrown} = '0;
        {capOne, capTwo, capFour} = '1;
        {evtMask, evtClr, evtPins} = '0;
        sh = '{default: 32'h0};
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        // Unmapped and read-only writes, then reset values
        xfer(12'h05C, 1'b1, 4'hF, 32'hFFFF_FFFF);
        xfer(`OFS_RAW_EVENT_STATUS, 1'b1, 4'hF, 32'hFFFF_FFFF);
        xfer(12'h05C, 1'b0, 4'hF, 32'h0);
        `CHK("unmapped", 32'h0000_0000, got)
        xfer(`OFS_RAW_EVENT_STATUS, 1'b0, 4'hF, 32'h0);
        `CHK("raw reset", 32'h0000_0000, got)
        for (int i = 0; i < 4; i++) begin
            xfer(adr[i], 1'b0, 4'hF, 32'h0);
            `CHK("reg reset", 32'h0000_0000, got)
        end
        // Random writes under random capabilities and lanes
        for (int it = 0; it < 60; it++) begin
            r = $random(seed);
            k = r[1:0];
            s = r[7:4];
            capOne <= (it == 0) ? 32'h0 : (it == 1) ? 32'hFFFF_FFFF : $random(seed);
            capTwo <= (it == 0) ? 32'h0 : (it == 1) ? 32'hFFFF_FFFF : $random(seed);
            capFour <= (it == 0) ? 32'h0 : (it == 1) ? 32'hFFFF_FFFF : $random(seed);
            d = $random(seed) & impl[k];
            c = $unsigned($random(seed)) % 11;
            if (k == 0) d = (c < 5) ? 32'h0000_001B + c : c - 5;
            xfer(adr[k], 1'b1, s, d);
            cap = (k == 1) ? capOne : (k == 2) ? capTwo : (k == 3) ? capFour : 32'hFFFF_FFFF;
            sh[k] = merge(sh[k], d, s, impl[k], cap);
            xfer(adr[k], 1'b0, 4'hF, 32'h0);
            `CHK("readback", sh[k], got)
            `CHK("select", sh[0][5:0], regSel)
            `CHK("resets", {sh[1][3], sh[2][25:24], sh[2][17:16], sh[2][4], sh[2][0],
                sh[3][2:0]}, rstOut)
        end
        // Mid-run reset returns every written register to zero
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        `CHK("select cleared", 6'h00, regSel)
        `CHK("resets cleared", 10'h000, rstOut)
        for (int i = 0; i < 4; i++) begin
            xfer(adr[i], 1'b0, 4'hF, 32'h0);
            `CHK("reset again", 32'h0000_0000, got)
        end
        // Each event source; bit 1 twice for both brown-out modes
        for (int i = 0; i < 8; i++) begin
            b = (i == 7) ? 1 : i;
            bitv = 7'h01 << b;
            r = $random(seed);
            m = (i == 0) ? 7'h00 : (r[6:0] | bitv);
            evtMask <= m;
            selBrown <= (i == 7);
            evtPins <= bitv;
            repeat (10) @(posedge core_clk);
            xfer(`OFS_RAW_EVENT_STATUS, 1'b0, 4'hF, 32'h0);
            `CHK("raw set", {25'h0, bitv}, got)
            `CHK("masked", bitv & m, maskedEvents)
            `CHK("brownout irq", bitv[1] & m[1] & (i != 7), brIrq)
            `CHK("brownout reset", bitv[1] & (i == 7), brRst)
            `CHK("irq", |(bitv & m & 7'h7D) | (bitv[1] & m[1] & (i != 7)), ctlIrq)
            evtClr <= bitv;
            @(posedge core_clk);
            evtClr <= 7'h00;
            evtPins <= 7'h00;
            repeat (8) @(posedge core_clk);
            xfer(`OFS_RAW_EVENT_STATUS, 1'b0, 4'hF, 32'h0);
            `CHK("raw held", {25'h0, bitv}, got)
            evtClr <= bitv;
            @(posedge core_clk);
            evtClr <= 7'h00;
            xfer(`OFS_RAW_EVENT_STATUS, 1'b0, 4'hF, 32'h0);
            `CHK("raw cleared", 32'h0000_0000, got)
        end
        conclude();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errTotal++;
        conclude();
    end
endmodule // system_control_regs_bench
